//--- inc/bwd_regs.svh
// timing counts and fixed values for the remote wake-up detector
`ifndef BWD_REGS_SVH
`define BWD_REGS_SVH
`define BWD_CLK_NS        20
`define BWD_DET_NS        2000
`define BWD_DET_CYC       ((`BWD_DET_NS + `BWD_CLK_NS - 1) / `BWD_CLK_NS)
`define BWD_INT_NS        500
`define BWD_INT_CYC       (`BWD_INT_NS / `BWD_CLK_NS)
`define BWD_WIN_US        100
`define BWD_WIN_CYC       ((`BWD_WIN_US * 1000) / `BWD_CLK_NS)
`define BWD_BIT_NS        100
`define BWD_BIT_CYC       (`BWD_BIT_NS / `BWD_CLK_NS)
`define BWD_BIT_MID       2
`define BWD_PAY_LEN       26
`define BWD_BYTE_ONES     8'hFF
`define BWD_BYTE_ZERO     8'h00
`define BWD_RUN_LEN       5
`define BWD_IDLE_BITS     11
`endif

//--- inc/bwd_pkg.sv
// types shared by the remote wake-up detector
package bwd_pkg;
  typedef enum logic [1:0] {
    BWD_IDLE  = 2'b00,
    BWD_DATA0 = 2'b01,
    BWD_DATA1 = 2'b10
  } bwd_sym_t;
  typedef enum logic [1:0] {
    BWD_SEEK  = 2'b00,
    BWD_FIRST = 2'b01,
    BWD_SEP   = 2'b11
  } bwd_pat_t;
endpackage : bwd_pkg

//--- inc/bwd_sym_if.sv
// bus symbol in, qualified phase out, between top and phase filter
`timescale 1ns/100ps
interface bwd_sym_if;
  import bwd_pkg::*;
  bwd_sym_t sym_raw;
  bwd_sym_t phase;
  logic     qual;
  modport filt (input sym_raw, output phase, output qual);
  modport user (output sym_raw, input phase, input qual);
endinterface : bwd_sym_if

//--- hw/bwd_phase.sv
// phase filter: qualifies a bus phase and rides over short interruptions
`timescale 1ns/100ps
`include "bwd_regs.svh"
module bwd_phase import bwd_pkg::*; (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic clr,
  bwd_sym_if.filt   sif
);
  localparam logic [7:0] DET_CYC = 8'(`BWD_DET_CYC);
  localparam logic [5:0] INT_CYC = 6'(`BWD_INT_CYC);

  bwd_sym_t   cur_reg, cur_next;
  logic [7:0] run_reg, run_next;
  logic [5:0] int_reg, int_next;
  logic       qual_reg, qual_next;

  // next phase state; a foreign symbol only ends the phase once it outlasts the timeout
  always_comb begin
    cur_next  = cur_reg;
    run_next  = run_reg;
    int_next  = 6'h00;
    qual_next = 1'b0;
    if (clr) begin
      cur_next = BWD_IDLE;
      run_next = 8'h00;
    end else if (sif.sym_raw != cur_reg && int_reg + 6'h01 >= INT_CYC) begin
      cur_next = sif.sym_raw;
      run_next = 8'h00;
    end else begin
      if (sif.sym_raw != cur_reg) begin
        int_next = int_reg + 6'h01;
      end
      if (run_reg < DET_CYC) begin
        run_next  = run_reg + 8'h01;
        qual_next = (run_reg == DET_CYC - 8'h01);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cur_reg  <= BWD_IDLE;
      run_reg  <= 8'h00;
      int_reg  <= 6'h00;
      qual_reg <= 1'b0;
    end else begin
      cur_reg  <= cur_next;
      run_reg  <= run_next;
      int_reg  <= int_next;
      qual_reg <= qual_next;
    end
  end

  assign sif.phase = cur_reg;
  assign sif.qual  = qual_reg;
endmodule : bwd_phase

//--- hw/bwd_top.sv
// remote wake-up detector: pattern search, wake frame search, wake flag and fault pin
`timescale 1ns/100ps
`include "bwd_regs.svh"
module bwd_top import bwd_pkg::*; #(
  parameter int unsigned WU_WINDOW_CYC = `BWD_WIN_CYC
) (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic BUS_LINE_POS,
  input  wire logic BUS_LINE_NEG,
  input  wire logic MODE_SELECT_LOW,
  input  wire logic VCC_PRESENT,
  input  wire logic ERROR_FLAG,
  input  wire logic WAKE_CLEAR,
  output logic      WAKE_FLAG,
  output logic      FAULT_INDICATE_LOW
);
  localparam logic [2:0] BIT_CYC = 3'(`BWD_BIT_CYC);
  localparam logic [4:0] PAY_LEN = 5'(`BWD_PAY_LEN);
  localparam logic [4:0] RUN_LEN = 5'(`BWD_RUN_LEN);
  localparam logic [3:0] IDL_LEN = 4'(`BWD_IDLE_BITS);

  // two-stage synchronisers for the bus, mode and supply pins
  logic [3:0] s1_reg, s2_reg;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
    end else begin
      s1_reg <= {VCC_PRESENT, MODE_SELECT_LOW, BUS_LINE_NEG, BUS_LINE_POS};
      s2_reg <= s1_reg;
    end
  end

  logic pos, neg, standby, vcc_ok;
  assign pos     = s2_reg[0];
  assign neg     = s2_reg[1];
  assign standby = ~s2_reg[2];
  assign vcc_ok  = s2_reg[3];

  // bus state decode from the receiver lines
  bwd_sym_if sif ();
  always_comb begin
    if (pos && !neg) begin
      sif.sym_raw = BWD_DATA1;
    end else if (!pos && neg) begin
      sif.sym_raw = BWD_DATA0;
    end else begin
      sif.sym_raw = BWD_IDLE;
    end
  end

  // monitoring runs whenever the core supply is there, in either mode
  bwd_phase u_phase (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .clr     (!vcc_ok),
    .sif     (sif)
  );

  // ---- wake pattern search ----
  bwd_pat_t    pat_reg, pat_next;
  logic [12:0] win_reg, win_next;
  logic        pat_done;
  logic        win_end;
  assign win_end = (win_reg >= 13'(WU_WINDOW_CYC - 1));

  // the mode input is not looked at here, so a mode change keeps the search alive
  always_comb begin
    pat_next = pat_reg;
    win_next = win_reg;
    pat_done = 1'b0;
    if (!vcc_ok) begin
      pat_next = BWD_SEEK;
      win_next = 13'h0000;
    end else begin
      unique case (pat_reg)
        BWD_SEEK: begin
          win_next = 13'h0000;
          if (sif.qual && sif.phase == BWD_DATA0) begin
            pat_next = BWD_FIRST;
          end
        end
        BWD_FIRST: begin
          win_next = win_reg + 13'h0001;
          if (win_end) begin
            pat_next = BWD_SEEK;
          end else if (sif.qual && sif.phase != BWD_DATA0) begin
            pat_next = BWD_SEP;
          end
        end
        BWD_SEP: begin
          win_next = win_reg + 13'h0001;
          if (win_end) begin
            pat_next = BWD_SEEK;
          end else if (sif.qual && sif.phase == BWD_DATA0) begin
            pat_done = 1'b1;
            pat_next = BWD_SEEK;
          end
        end
        default: begin
          pat_next = BWD_SEEK;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pat_reg <= BWD_SEEK;
      win_reg <= 13'h0000;
    end else begin
      pat_reg <= pat_next;
      win_reg <= win_next;
    end
  end

  // ---- wake frame search: bit sampling at 10 Mbit/s ----
  // a bus bit is low for Data_0 and high otherwise; falling edges realign the sampler
  logic       rx_bit;
  logic       prv_reg, prv_next;
  logic [2:0] div_reg, div_next;
  logic       smp;
  assign rx_bit = (sif.sym_raw != BWD_DATA0);
  assign smp    = (div_reg == 3'(`BWD_BIT_MID));

  always_comb begin
    prv_next = rx_bit;
    if (prv_reg && !rx_bit) begin
      div_next = 3'h0;
    end else if (div_reg == BIT_CYC - 3'h1) begin
      div_next = 3'h0;
    end else begin
      div_next = div_reg + 3'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prv_reg <= 1'b1;
      div_reg <= 3'h0;
    end else begin
      prv_reg <= prv_next;
      div_reg <= div_next;
    end
  end

  // byte framing: start sequence '1','0' ahead of every byte, msb first
  function automatic logic [7:0] exp_byte(input logic [4:0] idx);
    if ((idx / RUN_LEN) == 5'd1 || (idx / RUN_LEN) == 5'd3) begin
      return `BWD_BYTE_ZERO;
    end
    return `BWD_BYTE_ONES;
  endfunction : exp_byte

  logic       lbit_reg, lbit_next;
  logic [3:0] bpos_reg, bpos_next;
  logic [7:0] sh_reg, sh_next;
  logic [4:0] idx_reg, idx_next;
  logic [3:0] idl_reg, idl_next;
  logic       frm_done;
  logic [7:0] byte_in;
  assign byte_in = {sh_reg[6:0], rx_bit};

  // payload match counter; frame counts only once the bus falls idle after it
  always_comb begin
    lbit_next = lbit_reg;
    bpos_next = bpos_reg;
    sh_next   = sh_reg;
    idx_next  = idx_reg;
    idl_next  = idl_reg;
    frm_done  = 1'b0;
    if (!vcc_ok) begin
      bpos_next = 4'h0;
      idx_next  = 5'h00;
      idl_next  = 4'h0;
    end else if (smp) begin
      lbit_next = rx_bit;
      idl_next  = rx_bit ? ((idl_reg == IDL_LEN) ? idl_reg : idl_reg + 4'h1) : 4'h0;
      unique case (bpos_reg)
        4'h0: bpos_next = (lbit_reg && !rx_bit) ? 4'h1 : 4'h0;
        4'h9: bpos_next = rx_bit ? 4'hA : 4'h0;
        4'hA: bpos_next = rx_bit ? 4'h0 : 4'h1;
        default: begin
          sh_next   = byte_in;
          bpos_next = bpos_reg + 4'h1;
          if (bpos_reg == 4'h8 && idx_reg != PAY_LEN) begin
            if (byte_in == exp_byte(idx_reg)) begin
              idx_next = idx_reg + 5'h01;
            end else begin
              idx_next = (byte_in == `BWD_BYTE_ONES) ? 5'h01 : 5'h00;
            end
          end
        end
      endcase
      if (idl_next == IDL_LEN) begin
        bpos_next = 4'h0;
        idx_next  = 5'h00;
        frm_done  = (idx_reg == PAY_LEN);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lbit_reg <= 1'b1;
      bpos_reg <= 4'h0;
      sh_reg   <= 8'h00;
      idx_reg  <= 5'h00;
      idl_reg  <= 4'h0;
    end else begin
      lbit_reg <= lbit_next;
      bpos_reg <= bpos_next;
      sh_reg   <= sh_next;
      idx_reg  <= idx_next;
      idl_reg  <= idl_next;
    end
  end

  // ---- wake flag and fault pin ----
  logic wake_reg, wake_next, flt_reg, flt_next, wake_set;
  // only these two triggers set the flag, and they set it alike; set beats clear
  always_comb begin
    wake_set  = standby && vcc_ok && (pat_done || frm_done);
    wake_next = wake_set || (wake_reg && !WAKE_CLEAR);
    flt_next  = standby ? !wake_next : !ERROR_FLAG;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wake_reg <= 1'b0;
      flt_reg  <= 1'b1;
    end else begin
      wake_reg <= wake_next;
      flt_reg  <= flt_next;
    end
  end

  assign WAKE_FLAG          = wake_reg;
  assign FAULT_INDICATE_LOW = flt_reg;
endmodule : bwd_top

//--- tb/bwd_properties.sv
// port-level assertions for the remote wake-up detector
`timescale 1ns/100ps
module bwd_checker #(
  parameter int unsigned WU_WINDOW_CYC = 5000
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic BUS_LINE_POS,
  input wire logic BUS_LINE_NEG,
  input wire logic MODE_SELECT_LOW,
  input wire logic VCC_PRESENT,
  input wire logic ERROR_FLAG,
  input wire logic WAKE_CLEAR,
  input wire logic WAKE_FLAG,
  input wire logic FAULT_INDICATE_LOW
);
  logic [7:0] quiet_reg;
  logic [7:0] quiet_next;
  // cycles since Data_0 was last on the lines; saturates so it never wraps back
  always_comb begin
    quiet_next = quiet_reg;
    if (!BUS_LINE_POS && BUS_LINE_NEG) quiet_next = 8'h00;
    else if (quiet_reg != 8'hFF) quiet_next = quiet_reg + 8'h01;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) quiet_reg <= 8'h00;
    else quiet_reg <= quiet_next;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // every wake source needs recent Data_0 activity; sync and filter delays fit in 140 cycles
  quiet_no_wake_a: assert property ($rose(WAKE_FLAG) |-> quiet_reg < 8'h8C)
    else $error("wake without bus activity");
  flag_fall_cause_a: assert property ($fell(WAKE_FLAG) |-> $past(WAKE_CLEAR))
    else $error("wake flag fell without clear");
  wake_hold_a: assert property (WAKE_FLAG && !WAKE_CLEAR |=> WAKE_FLAG)
    else $error("wake flag dropped");
  clear_quiet_a: assert property (WAKE_CLEAR && quiet_reg > 8'h8C |=> !WAKE_FLAG)
    else $error("clear ignored");
  fault_standby_a: assert property (!MODE_SELECT_LOW [*4] |-> FAULT_INDICATE_LOW == !WAKE_FLAG)
    else $error("fault pin does not show wake flag");
  fault_err_a: assert property ((MODE_SELECT_LOW && ERROR_FLAG) [*4] |-> !FAULT_INDICATE_LOW)
    else $error("fault pin misses error");
  fault_noerr_a: assert property ((MODE_SELECT_LOW && !ERROR_FLAG) [*4] |-> FAULT_INDICATE_LOW)
    else $error("fault pin low without error");
  normal_no_wake_a: assert property (MODE_SELECT_LOW [*6] |-> !$rose(WAKE_FLAG))
    else $error("wake set in normal mode");
  supply_no_wake_a: assert property (!VCC_PRESENT [*6] |-> !$rose(WAKE_FLAG))
    else $error("wake set without supply");
endmodule : bwd_checker

bind bwd_top bwd_checker #(.WU_WINDOW_CYC(WU_WINDOW_CYC)) chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .BUS_LINE_POS(BUS_LINE_POS), .BUS_LINE_NEG(BUS_LINE_NEG),
  .MODE_SELECT_LOW(MODE_SELECT_LOW), .VCC_PRESENT(VCC_PRESENT), .ERROR_FLAG(ERROR_FLAG),
  .WAKE_CLEAR(WAKE_CLEAR), .WAKE_FLAG(WAKE_FLAG), .FAULT_INDICATE_LOW(FAULT_INDICATE_LOW));

//--- tb/bwd_bus_node.sv
// remote node model driving the differential bus lines
`timescale 1ns/100ps
module bwd_bus_node import bwd_pkg::*; (
  input  wire logic CLK,
  output logic      pos,
  output logic      neg
);
  // lines start equal, the low-power idle level
  initial begin
    pos = 1'b0;
    neg = 1'b0;
  end
  // one symbol held for a whole number of cycles, changed just after an edge
  task automatic hold(input bwd_sym_t sym, input int cycles);
    @(posedge CLK);
    #1;
    pos = (sym == BWD_DATA1);
    neg = (sym == BWD_DATA0);
    repeat (cycles - 1) @(posedge CLK);
  endtask : hold
  // wake frame payload, each byte led by a high and a low start bit, msb first
  task automatic send_frame;
    logic [7:0] b;
    for (int i = 0; i < 26; i++) begin
      b = (i < 5 || (i >= 10 && i < 15) || i >= 20) ? 8'hFF : 8'h00;
      hold(BWD_DATA1, 5);
      hold(BWD_DATA0, 5);
      for (int k = 7; k >= 0; k--) hold(b[k] ? BWD_DATA1 : BWD_DATA0, 5);
    end
    hold(BWD_DATA1, 55);
    hold(BWD_IDLE, 20);
  endtask : send_frame
endmodule : bwd_bus_node

//--- tb/bus_remote_wakeup_detector_tb_top.sv
// self-checking bench for the remote wake-up detector
`timescale 1ns/100ps
module bus_remote_wakeup_detector_tb_top import bwd_pkg::*;;
  localparam int unsigned WIN = 400;
  logic clk, sys_rst, bus_pos, bus_neg, mode_low, vcc_ok, err_flag, wake_clr, wake_flag, fault_low;
  int   mismatches, total_checks;
  bwd_top #(.WU_WINDOW_CYC(WIN)) dut_u (.CLK(clk), .SYS_RST(sys_rst), .BUS_LINE_POS(bus_pos),
    .BUS_LINE_NEG(bus_neg), .MODE_SELECT_LOW(mode_low), .VCC_PRESENT(vcc_ok), .ERROR_FLAG(err_flag),
    .WAKE_CLEAR(wake_clr), .WAKE_FLAG(wake_flag), .FAULT_INDICATE_LOW(fault_low));
  bwd_bus_node node_u (.CLK(clk), .pos(bus_pos), .neg(bus_neg));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic seen, input logic want, input string what);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: %s saw %b", $time, what, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // data0 and separator of given lengths, then 110 cycles of data0; the filter takes 25 cycles to accept a new phase
  // and 100 more to qualify it, so the last phase only counts after the bus moved on
  task automatic pat(input bwd_sym_t sep, input int d0a, input int sepn, input logic want);
    node_u.hold(BWD_DATA0, d0a);
    node_u.hold(sep, sepn);
    node_u.hold(BWD_DATA0, 110);
    node_u.hold(BWD_IDLE, 30);
    #1 check(wake_flag, want, "wake flag");
    check(fault_low, !want, "fault pin");
  endtask : pat
  // the flag must hold over a quiet bus first; clearing also waits out the window
  // so no partial pattern leaks onward
  task automatic clear_wake;
    node_u.hold(BWD_IDLE, 150);
    #1 check(wake_flag, 1'b1, "flag held");
    wake_clr = 1'b1;
    @(posedge clk);
    #1 wake_clr = 1'b0;
    check(wake_flag, 1'b0, "flag after clear");
    check(fault_low, 1'b1, "fault after clear");
    node_u.hold(BWD_IDLE, 500);
  endtask : clear_wake
  task automatic t_normal;
    #1 mode_low = 1'b1;
    pat(BWD_IDLE, 110, 110, 1'b0);
    #1 err_flag = 1'b1;
    node_u.hold(BWD_IDLE, 6);
    #1 check(fault_low, 1'b0, "error shown");
    err_flag = 1'b0;
    node_u.hold(BWD_IDLE, 6);
    #1 check(fault_low, 1'b1, "error gone");
    mode_low = 1'b0;
    node_u.hold(BWD_IDLE, 500);
  endtask : t_normal
  task automatic t_mode_change;
    #1 mode_low = 1'b1;
    node_u.hold(BWD_DATA0, 110);
    node_u.hold(BWD_IDLE, 50);
    #1 mode_low = 1'b0;
    pat(BWD_IDLE, 0, 60, 1'b1);
    clear_wake();
  endtask : t_mode_change
  initial begin
    sys_rst = 1'b1;
    {mode_low, err_flag, wake_clr} = 3'b000;
    vcc_ok = 1'b1;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 check(wake_flag, 1'b0, "reset flag");
    check(fault_low, 1'b1, "reset fault");
    pat(BWD_IDLE, 110, 110, 1'b1);
    clear_wake();
    pat(BWD_DATA1, 110, 110, 1'b1);
    clear_wake();
    node_u.hold(BWD_DATA0, 50);
    node_u.hold(BWD_IDLE, 10);
    pat(BWD_IDLE, 60, 110, 1'b1);
    clear_wake();
    pat(BWD_IDLE, 60, 110, 1'b0);
    node_u.hold(BWD_IDLE, 500);
    pat(BWD_IDLE, 110, 350, 1'b0);
    node_u.hold(BWD_IDLE, 500);
    t_normal();
    t_mode_change();
    #1 vcc_ok = 1'b0;
    pat(BWD_IDLE, 110, 110, 1'b0);
    vcc_ok = 1'b1;
    node_u.hold(BWD_IDLE, 500);
    node_u.send_frame();
    #1 check(wake_flag, 1'b1, "frame wake");
    clear_wake();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule : bus_remote_wakeup_detector_tb_top
